// File: sbrw_pkg.sv
package sbrw_pkg;
  // Runtime operating modes
  typedef enum logic [1:0] {
    MODE_DISABLED = 2'h0,
    MODE_ONE_TIME = 2'h1,
    MODE_SINGLE = 2'h2,
    MODE_REPEATED = 2'h3
  } sbrw_mode_type;
  // First-stage event choices
  localparam logic [1:0] EV1_NMI = 2'h0;
  localparam logic [1:0] EV1_ACPI = 2'h1;
  localparam logic [1:0] EV1_RESET = 2'h2;
  localparam logic [1:0] EV1_POWER = 2'h3;
  // Second-stage event choices
  localparam logic EV2_DISABLED = 1'h0;
  localparam logic EV2_NMI = 1'h1;
  // Slow tick: 1 ms at 50 MHz
  localparam int CLK_HZ = 50000000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
  localparam int TICK_W = 16;
  // Timeout and delay counts in ticks
  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
endpackage

// File: sbrw_watchdog.sv
`timescale 1ns/10ps
module sbrw_watchdog #(
  parameter int TICK_CYCLES = sbrw_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Boot-time watchdog control
  input wire logic bootEnable,
  input wire logic [sbrw_pkg::CNT_W-1:0] bootTimeout,
  input wire logic pauseOnInteract,
  input wire logic menuShown,
  input wire logic passwordEntry,
  input wire logic bootDone,
  // Runtime configuration
  input wire logic [1:0] runMode,
  input wire logic [sbrw_pkg::CNT_W-1:0] startDelay,
  input wire logic [sbrw_pkg::CNT_W-1:0] timeout1,
  input wire logic [sbrw_pkg::CNT_W-1:0] timeout2,
  input wire logic [1:0] event1Sel,
  input wire logic event2Sel,
  // Software strobes
  input wire logic osBootStart,
  input wire logic trigger,
  // Event outputs, one-cycle pulses
  output logic nmiPulse,
  output logic acpiPulse,
  output logic resetPulse,
  output logic powerPulse,
  // Status
  output logic bootActive,
  output logic runActive
);

  ////////////////////////////////////////////////////////////////
  // Runtime states, Gray along delay -> stage1 -> stage2
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_DELAY = 2'h1,
    ST_STAGE1 = 2'h3,
    ST_STAGE2 = 2'h2
  } sbrw_state_type;

  sbrw_state_type state; // Runtime state
  sbrw_state_type next_state; // Next runtime state
  sbrw_pkg::sbrw_mode_type mode; // Mode latched at arming
  logic [sbrw_pkg::TICK_W-1:0] tickCnt; // Prescaler
  logic tick; // One-cycle slow enable
  logic [sbrw_pkg::CNT_W-1:0] bootCnt; // Boot countdown
  logic [sbrw_pkg::CNT_W-1:0] runCnt; // Runtime countdown
  logic [sbrw_pkg::CNT_W-1:0] next_runCnt; // Next runtime count
  logic bootRun; // Boot watchdog running

  ////////////////////////////////////////////////////////////////
  // Slow tick divider
  wire tickWrap = (tickCnt == sbrw_pkg::TICK_W'(TICK_CYCLES - 1));

  always_ff @(posedge mclk) begin
    if (srst || tickWrap) begin
      tickCnt <= '0;
    end else begin
      tickCnt <= tickCnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      tick <= 1'b0;
    end else begin
      tick <= tickWrap;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Boot-time watchdog guarding self test
  // pause on interaction
  wire bootPaused = pauseOnInteract && (menuShown || passwordEntry);
  wire bootExpire = bootRun && tick && !bootPaused && (bootCnt <= sbrw_pkg::CNT_ONE);

  // Boot counter loads at reset release, stops when boot is done
  always_ff @(posedge mclk) begin
    if (srst) begin
      bootRun <= 1'b0;
      bootCnt <= sbrw_pkg::CNT_ZERO;
    end else if (bootDone || osBootStart) begin
      bootRun <= 1'b0;
    end else if (bootEnable && !bootRun && bootCnt == sbrw_pkg::CNT_ZERO) begin
      bootRun <= 1'b1;
      bootCnt <= bootTimeout;
    end else if (bootExpire) begin
      // Expiry forces a reset; no rearm until system reset
      bootRun <= 1'b0;
      bootCnt <= sbrw_pkg::CNT_ONE;
    end else if (bootRun && tick && !bootPaused) begin
      bootCnt <= bootCnt - sbrw_pkg::CNT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Runtime sequencing
  wire runExpire = tick && (runCnt <= sbrw_pkg::CNT_ONE);
  wire modeOff = (sbrw_pkg::sbrw_mode_type'(runMode) == sbrw_pkg::MODE_DISABLED);
  wire stage2On = (event2Sel != sbrw_pkg::EV2_DISABLED);
  wire inStage = (state == ST_STAGE1) || (state == ST_STAGE2);
  wire fire1 = (state == ST_STAGE1) && runExpire && !trigger;
  wire fire2 = (state == ST_STAGE2) && runExpire && !trigger;

  always_comb begin
    next_state = state;
    next_runCnt = runCnt;
    case (state)
      ST_IDLE: begin
        if (osBootStart && !modeOff) begin
          next_state = ST_DELAY;
          next_runCnt = startDelay;
        end
      end
      ST_DELAY: begin
        if (tick) begin
          if (runExpire) begin
            next_state = ST_STAGE1;
            next_runCnt = timeout1;
          end else begin
            next_runCnt = runCnt - sbrw_pkg::CNT_ONE;
          end
        end
      end
      ST_STAGE1: begin
        if (trigger) begin
          if (mode == sbrw_pkg::MODE_ONE_TIME) begin
            next_state = ST_IDLE;
          end else begin
            next_runCnt = timeout1;
          end
        end else if (runExpire) begin
          if (stage2On) begin
            next_state = ST_STAGE2;
            next_runCnt = timeout2;
          end else if (mode == sbrw_pkg::MODE_REPEATED) begin
            // stage one is last; repeat it
            next_runCnt = timeout1;
          end else begin
            next_state = ST_IDLE;
          end
        end else if (tick) begin
          next_runCnt = runCnt - sbrw_pkg::CNT_ONE;
        end
      end
      ST_STAGE2: begin
        if (trigger) begin
          if (mode == sbrw_pkg::MODE_ONE_TIME) begin
            next_state = ST_IDLE;
          end else begin
            next_state = ST_STAGE1;
            next_runCnt = timeout1;
          end
        end else if (runExpire) begin
          if (mode == sbrw_pkg::MODE_REPEATED) begin
            next_runCnt = timeout2;
          end else begin
            next_state = ST_IDLE;
          end
        end else if (tick) begin
          next_runCnt = runCnt - sbrw_pkg::CNT_ONE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Mode is latched at arming so later edits do not upset a running pass
  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= ST_IDLE;
      runCnt <= sbrw_pkg::CNT_ZERO;
      mode <= sbrw_pkg::MODE_DISABLED;
    end else begin
      state <= next_state;
      runCnt <= next_runCnt;
      if (state == ST_IDLE && osBootStart) begin
        mode <= sbrw_pkg::sbrw_mode_type'(runMode);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Event selection
  // first event select
  wire ev1Nmi = fire1 && (event1Sel == sbrw_pkg::EV1_NMI);
  wire ev1Acpi = fire1 && (event1Sel == sbrw_pkg::EV1_ACPI);
  wire ev1Reset = fire1 && (event1Sel == sbrw_pkg::EV1_RESET);
  wire ev1Power = fire1 && (event1Sel == sbrw_pkg::EV1_POWER);
  wire ev2Nmi = fire2 && (event2Sel == sbrw_pkg::EV2_NMI);

  // Registered event pulses and status
  always_ff @(posedge mclk) begin
    if (srst) begin
      nmiPulse <= 1'b0;
      acpiPulse <= 1'b0;
      resetPulse <= 1'b0;
      powerPulse <= 1'b0;
      bootActive <= 1'b0;
      runActive <= 1'b0;
    end else begin
      nmiPulse <= ev1Nmi || ev2Nmi;
      acpiPulse <= ev1Acpi;
      resetPulse <= ev1Reset || bootExpire;
      powerPulse <= ev1Power;
      bootActive <= bootRun;
      runActive <= inStage;
    end
  end

endmodule // sbrw_watchdog

// File: sbrw_watchdog_properties.sv
`timescale 1ns/10ps
module sbrw_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Watched ports
  input wire logic menuShown,
  input wire logic pauseOnInteract,
  input wire logic [1:0] runMode,
  input wire logic [1:0] event1Sel,
  input wire logic event2Sel,
  input wire logic osBootStart,
  input wire logic trigger,
  input wire logic nmiPulse,
  input wire logic acpiPulse,
  input wire logic resetPulse,
  input wire logic powerPulse,
  input wire logic bootActive,
  input wire logic runActive
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (srst);
  logic armed; // Arming seen since reset
  logic anyEv; // Any event pulse
  assign anyEv = nmiPulse | acpiPulse | resetPulse | powerPulse;
  // Arming history
  always_ff @(posedge mclk) begin
    armed <= srst ? 1'h0 : armed | osBootStart;
  end
  ////////////////////////////////////////////////////////////
  property p_pulse; anyEv |=> !anyEv; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse too long");
  property p_acpi; acpiPulse |-> $past(event1Sel) == sbrw_pkg::EV1_ACPI; endproperty
  a_acpi: assert property (p_acpi) else $error("stray acpi");
  property p_power; powerPulse |-> $past(event1Sel) == sbrw_pkg::EV1_POWER; endproperty
  a_power: assert property (p_power) else $error("stray power");
  property p_nmi; nmiPulse |-> $past(event1Sel) == sbrw_pkg::EV1_NMI || $past(event2Sel); endproperty
  a_nmi: assert property (p_nmi) else $error("stray nmi");
  property p_arm; runActive |-> armed; endproperty
  a_arm: assert property (p_arm) else $error("active unarmed");
  property p_trig; trigger && runActive |=> !anyEv [*3]; endproperty
  a_trig: assert property (p_trig) else $error("event after kick");
  property p_once; trigger && runActive && runMode == sbrw_pkg::MODE_ONE_TIME |-> ##[1:3] !runActive; endproperty
  a_once: assert property (p_once) else $error("one-time kept on");
  // Next cycle only: the menu may close one cycle later and then expiry is legal
  property p_pause; bootActive && pauseOnInteract && menuShown |=> !resetPulse; endproperty
  a_pause: assert property (p_pause) else $error("reset in pause");
  c_acpi: cover property (acpiPulse);
  c_kick: cover property (trigger && runActive);
  c_rep: cover property (nmiPulse ##[1:40] nmiPulse);
endmodule // sbrw_props
bind sbrw_watchdog sbrw_props i_chk (.*);

// File: sbrw_watchdog_tb.sv
`timescale 1ns/10ps
module sbrw_watchdog_tb;
  logic mclk = 1'h0;
  logic srst = 1'h1;
  logic bootEnable = 1'h1;
  logic pauseOnInteract = 1'h1;
  logic menuShown = 1'h1;
  logic passwordEntry = 1'h0;
  logic bootDone = 1'h0; // Self test finished strobe
  logic trigger = 1'h0;
  logic osBootStart = 1'h0;
  logic [1:0] runMode = 2'h0;
  logic [1:0] event1Sel = 2'h0;
  logic event2Sel = 1'h0;
  logic nmiPulse, acpiPulse, resetPulse, powerPulse, bootActive, runActive;
  int errors = 0;
  int check_count = 0;
  int n; // Cycles waited
  wire [3:0] ev = {powerPulse, resetPulse, acpiPulse, nmiPulse};
  always #10 mclk = ~mclk;
  // Short tick keeps runs brief; delay 2, timeouts 3 and 2 ticks
  sbrw_watchdog #(.TICK_CYCLES(4)) i_dut (.bootTimeout(24'h000003),
    .startDelay(24'h000002), .timeout1(24'h000003), .timeout2(24'h000002), .*);
  ////////////////////////////////////////////////////////////
  task step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task report_and_stop();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Bounded wait for any event
  task wev(input int lim);
    n = 0;
    do begin
      step(1);
      n++;
    end while (n <= lim && ev === 4'h0);
  endtask
  task quiet(input int k);
    wev(k);
    chk("quiet", n, k + 1);
  endtask
  // Expect event e about t ticks on
  task win(input logic [3:0] e, input int t);
    wev(t * 4 + 8);
    chk("kind", ev, e);
    chk("time", n >= t * 4 - 4 && n <= t * 4 + 4, 1);
    if (n > t * 4 + 8)
      report_and_stop();
  endtask
  // Reset, configure, idle, then arm
  task arm(input logic [1:0] md, input logic [1:0] e1, input logic e2);
    $display("test ends, checks %0d", check_count);
    srst = 1'h1;
    bootEnable = 1'h0;
    runMode = md;
    event1Sel = e1;
    event2Sel = e2;
    step(8);
    srst = 1'h0;
    quiet(20);
    osBootStart = 1'h1;
    step(1);
    osBootStart = 1'h0;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    step(8);
    srst = 1'h0;
    quiet(40);
    menuShown = 1'h0;
    passwordEntry = 1'h1;
    quiet(40);
    passwordEntry = 1'h0;
    win(4'h4, 3);
    // Boot done ends the boot watchdog early
    srst = 1'h1;
    step(8);
    srst = 1'h0;
    step(2);
    chk("bootActive", bootActive, 1'h1);
    bootDone = 1'h1;
    step(1);
    bootDone = 1'h0;
    quiet(40);
    chk("bootActive", bootActive, 1'h0);
    // Every first event, then stage two once
    for (int s = 0; s < 4; s++) begin
      arm(sbrw_pkg::MODE_SINGLE, s[1:0], 1'h1);
      win(4'h1 << s, 5);
      win(4'h1, 2);
      quiet(60);
      chk("runActive", runActive, 1'h0);
    end
    arm(sbrw_pkg::MODE_REPEATED, sbrw_pkg::EV1_POWER, sbrw_pkg::EV2_DISABLED);
    win(4'h8, 5);
    chk("runActive", runActive, 1'h1);
    win(4'h8, 3);
    arm(sbrw_pkg::MODE_REPEATED, sbrw_pkg::EV1_ACPI, sbrw_pkg::EV2_NMI);
    win(4'h2, 5);
    win(4'h1, 2);
    win(4'h1, 2);
    // Kicks hold off events; one-time then stops
    for (int m = 1; m < 3; m++) begin
      arm(m[1:0], sbrw_pkg::EV1_RESET, 1'h1);
      step(5);
      repeat (6) begin
        step(7);
        trigger = 1'h1;
        step(1);
        trigger = 1'h0;
      end
      if (m == 1) begin
        quiet(60);
        chk("runActive", runActive, 1'h0);
      end else begin
        win(4'h4, 3);
      end
    end
    arm(sbrw_pkg::MODE_DISABLED, sbrw_pkg::EV1_NMI, 1'h1);
    quiet(80);
    report_and_stop();
  end
endmodule // sbrw_watchdog_tb
